// ==== pkg/src_pkg.sv ====
// constants for the remote command subset block
// assumes a 10 MHz system clock and an AXI4-Lite master
`default_nettype none
package src_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned ST_W = 8;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_DELAY = 8'h08;
   localparam logic [7:0] REG_LIVE = 8'h0C;
   localparam logic [7:0] REG_ACCUM = 8'h10;
   localparam logic [7:0] REG_FAULT = 8'h14;
   localparam logic [7:0] REG_REMAIN = 8'h18;
   // control register fields
   localparam int unsigned CTRL_AUX_ONE = 0;
   localparam int unsigned CTRL_AUX_TWO = 1;
   localparam int unsigned CTRL_CAL = 2;
   localparam int unsigned CTRL_PEND = 3;
   // command register fields, one-shot
   localparam int unsigned CMD_CLEAR = 0;
   localparam int unsigned CMD_VOLTAGE_SETTING_CMD = 1;
   localparam int unsigned CMD_CURRENT_SETTING_CMD = 2;
   localparam int unsigned CMD_PROT_RST = 3;
   localparam int unsigned CMD_TRIGGER = 4;
   localparam int unsigned CMD_OUT_ON = 5;
   localparam int unsigned CMD_PROG_ERR = 6;
   // status bit positions
   localparam int unsigned ST_CV = 0;
   localparam int unsigned ST_CC = 1;
   localparam int unsigned ST_FOLD = 3;
   localparam int unsigned ST_ERR = 7;
   localparam logic [ST_W-1:0] MODE_MASK = 8'h0B;
   // timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned DLY_STEP_MS = 32;
   localparam int unsigned DLY_MAX_S = 32;
   localparam int unsigned DLY_INIT_MS = 500;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * DLY_STEP_MS;
   localparam logic [15:0] DLY_MAX_TICKS = 16'(DLY_MAX_S * 1000 / DLY_STEP_MS);
   localparam logic [15:0] DLY_INIT_TICKS = 16'((DLY_INIT_MS + DLY_STEP_MS / 2) / DLY_STEP_MS);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== rtl/src_cmd_top.sv ====
// remote command subset: aux lines, clear, calibration flag, fault delay,
// accumulated status and fault registers behind an AXI4-Lite slave
// assumes synchronous inputs on aclk and a single outstanding access per channel
//
// Behaviour
// - accumulated bit sets if live bit was 1 since last read
// - accumulated register uses the live register's bit layout
// - reading accumulated status clears it afterwards
// - status reads return the plain sum of set bit weights
// - aux one on/off setting drives active-low line, resets off
// - aux one readback returns stored setting, 0 off 1 on
// - aux two on/off setting drives active-low line, resets off
// - aux two readback returns stored setting, 0 off 1 on
// - clear restores remote settings to power-on defaults
// - clear in local loads defaults, applied only once remote
// - clear empties the fault register
// - clear leaves calibration mode untouched
// - calibration mode follows on/off write, starts off
// - calibration readback gives 0 disabled, 1 enabled
// - fault delay 0..32 s in 32 ms steps, starts at 16 steps (512 ms)
// - voltage, current, reset, trigger, output-on restart the delay
// - running delay blocks CV, CC and foldback faults
// - programming error discards the rest of that command word
// - reading fault register clears it and the fault line
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`default_nettype none
module src_cmd_top
   import src_pkg::*;
#(
   parameter int unsigned TICK_CYC = TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic [ST_W-1:0] status_live,
   input wire logic local_mode,
   output logic aux_output_one_n,
   output logic aux_output_two_n,
   output logic calibration_mode_flag,
   output logic fault_line,
   output logic delay_running
);
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_DELAY) || (a == REG_LIVE) ||
               (a == REG_ACCUM) || (a == REG_FAULT) || (a == REG_REMAIN);
   endfunction

   // bus state
   logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_fire, rd_fire, wr_en;
   logic [ST_W-1:0] status_sum;

   assign wr_fire = awready_q && awvalid && wvalid;
   assign rd_fire = arready_q && arvalid;
   assign wr_en = wr_fire && wstrb[0];

   // block state
   logic aux_one_q, aux_one_d, aux_two_q, aux_two_d, cal_q, cal_d;
   logic pend_q, pend_d, aux_one_n_q, aux_one_n_d, aux_two_n_q, aux_two_n_d;
   logic [15:0] dly_set_q, dly_set_d, dly_cnt_q, dly_cnt_d;
   logic [31:0] pre_q, pre_d;
   logic [ST_W-1:0] accum_q, accum_d, fault_q, fault_d;
   logic fault_line_q, fault_line_d, running_q, running_d;
   logic [6:0] cmd;
   logic restart;

   always_comb begin
      cmd = 7'h00;
      if (wr_en && awaddr == REG_CMD) begin
         // error drops the remaining commands of the word
         cmd = wdata[CMD_PROG_ERR] ? 7'h40 : wdata[6:0];
      end
   end

   assign restart = cmd[CMD_VOLTAGE_SETTING_CMD] | cmd[CMD_CURRENT_SETTING_CMD] | cmd[CMD_PROT_RST] |
                    cmd[CMD_TRIGGER] | cmd[CMD_OUT_ON];
   assign status_sum = status_live | (cmd[CMD_PROG_ERR] ? ST_W'(1) << ST_ERR : '0);

   // bus handshake
   always_comb begin
      awready_d = awvalid && wvalid && !awready_q && !bvalid_q;
      wready_d = awready_d;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (bvalid_q && bready) begin
         bvalid_d = 1'b0;
      end
      if (wr_fire) begin
         bvalid_d = 1'b1;
         bresp_d = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end
      arready_d = arvalid && !arready_q && !rvalid_q;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (rvalid_q && rready) begin
         rvalid_d = 1'b0;
      end
      if (rd_fire) begin
         rvalid_d = 1'b1;
         rresp_d = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_d = 32'h0000_0000;
         unique case (araddr)
            REG_CTRL: begin
               rdata_d[CTRL_AUX_ONE] = aux_one_q;
               rdata_d[CTRL_AUX_TWO] = aux_two_q;
               rdata_d[CTRL_CAL] = cal_q;
               rdata_d[CTRL_PEND] = pend_q;
            end
            REG_DELAY: rdata_d[15:0] = dly_set_q;
            REG_LIVE: rdata_d[ST_W-1:0] = status_live;
            REG_ACCUM: rdata_d[ST_W-1:0] = accum_q;
            REG_FAULT: rdata_d[ST_W-1:0] = fault_q;
            REG_REMAIN: rdata_d[15:0] = dly_cnt_q;
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // settings, clear and calibration
   always_comb begin
      aux_one_d = aux_one_q;
      aux_two_d = aux_two_q;
      cal_d = cal_q;
      dly_set_d = dly_set_q;
      pend_d = pend_q && local_mode;
      if (wr_en && awaddr == REG_CTRL) begin
         aux_one_d = wdata[CTRL_AUX_ONE];
         aux_two_d = wdata[CTRL_AUX_TWO];
         cal_d = wdata[CTRL_CAL];
      end
      if (wr_en && awaddr == REG_DELAY) begin
         dly_set_d = (wdata[15:0] > DLY_MAX_TICKS) ? DLY_MAX_TICKS : wdata[15:0];
      end
      if (cmd[CMD_CLEAR]) begin
         // calibration flag deliberately kept
         aux_one_d = 1'b0;
         aux_two_d = 1'b0;
         dly_set_d = DLY_INIT_TICKS;
         pend_d = local_mode;
      end
      // outputs follow settings only under remote control
      aux_one_n_d = local_mode ? aux_one_n_q : ~aux_one_d;
      aux_two_n_d = local_mode ? aux_two_n_q : ~aux_two_d;
   end

   // fault delay counter
   always_comb begin
      pre_d = pre_q;
      dly_cnt_d = dly_cnt_q;
      if (restart) begin
         dly_cnt_d = dly_set_q;
         pre_d = 32'h0000_0000;
      end else if (dly_cnt_q != 16'h0000) begin
         if (pre_q >= 32'(TICK_CYC - 1)) begin
            pre_d = 32'h0000_0000;
            dly_cnt_d = dly_cnt_q - 16'h0001;
         end else begin
            pre_d = pre_q + 32'h0000_0001;
         end
      end
      running_d = dly_cnt_d != 16'h0000;
   end

   // accumulated status and fault registers
   always_comb begin
      logic [ST_W-1:0] src;
      src = status_sum;
      if (dly_cnt_q != 16'h0000) begin
         src = status_sum & ~MODE_MASK;
      end
      accum_d = accum_q;
      if (rd_fire && araddr == REG_ACCUM) begin
         accum_d = '0;
      end
      accum_d = accum_d | status_sum;
      fault_d = fault_q;
      if ((rd_fire && araddr == REG_FAULT) || cmd[CMD_CLEAR]) begin
         fault_d = '0;
      end
      fault_d = fault_d | src;
      fault_line_d = |fault_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         aux_one_q <= 1'b0;
         aux_two_q <= 1'b0;
         cal_q <= 1'b0;
         pend_q <= 1'b0;
         aux_one_n_q <= 1'b1;
         aux_two_n_q <= 1'b1;
         dly_set_q <= DLY_INIT_TICKS;
         dly_cnt_q <= 16'h0000;
         pre_q <= 32'h0000_0000;
         running_q <= 1'b0;
         accum_q <= '0;
         fault_q <= '0;
         fault_line_q <= 1'b0;
      end else begin
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         aux_one_q <= aux_one_d;
         aux_two_q <= aux_two_d;
         cal_q <= cal_d;
         pend_q <= pend_d;
         aux_one_n_q <= aux_one_n_d;
         aux_two_n_q <= aux_two_n_d;
         dly_set_q <= dly_set_d;
         dly_cnt_q <= dly_cnt_d;
         pre_q <= pre_d;
         running_q <= running_d;
         accum_q <= accum_d;
         fault_q <= fault_d;
         fault_line_q <= fault_line_d;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
   assign aux_output_one_n = aux_one_n_q;
   assign aux_output_two_n = aux_two_n_q;
   assign calibration_mode_flag = cal_q;
   assign fault_line = fault_line_q;
   assign delay_running = running_q;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_accum_catch: assert property (status_live[0] |=> accum_q[0])
      else $error("accumulated bit missed a live pulse");
   a_accum_clear: assert property (rd_fire && araddr == REG_ACCUM && status_live == '0
      |=> accum_q == '0)
      else $error("accumulated register not cleared by read");
   a_accum_read: assert property (rd_fire && araddr == REG_ACCUM |=> rdata_q[ST_W-1:0] ==
      $past(accum_q))
      else $error("accumulated read value wrong");
   a_aux_one_drive: assert property (wr_en && awaddr == REG_CTRL && !local_mode && !cmd[0]
      |=> aux_output_one_n == !$past(wdata[0]))
      else $error("aux one line wrong");
   a_aux_two_local: assert property (local_mode |=> $stable(aux_output_two_n))
      else $error("aux two changed in local mode");
   a_clear_keeps_cal: assert property (cmd[CMD_CLEAR] |=> $stable(cal_q))
      else $error("clear changed calibration flag");
   a_clear_fault: assert property (cmd[CMD_CLEAR] && status_live == '0 |=> fault_q == '0)
      else $error("clear left faults");
   a_delay_gate: assert property (dly_cnt_q != 16'h0000 && fault_q[ST_CV] == 1'b0 &&
      !cmd[CMD_CLEAR] |=> fault_q[ST_CV] == 1'b0)
      else $error("mode fault during delay");
   a_delay_reload: assert property (restart |=> dly_cnt_q == $past(dly_set_q))
      else $error("delay not reloaded");
   a_delay_limit: assert property (dly_set_q <= DLY_MAX_TICKS)
      else $error("delay setting above range");
   a_fault_line: assert property (rd_fire && araddr == REG_FAULT && status_live == '0 &&
      dly_cnt_q == 16'h0000 |=> !fault_line ##0 fault_q == '0)
      else $error("fault read did not clear");
   a_err_discard: assert property (wr_en && awaddr == REG_CMD && wdata[CMD_PROG_ERR]
      |=> $stable(aux_one_q) && accum_q[ST_ERR])
      else $error("error word not discarded");

   c_accum_read: cover property (rd_fire && araddr == REG_ACCUM && accum_q != '0);
   c_clear_local: cover property (cmd[CMD_CLEAR] && local_mode ##[1:20] !local_mode);
   c_delay_expire: cover property (delay_running ##1 !delay_running);
   c_fault_read: cover property (fault_line && rd_fire && araddr == REG_FAULT);
endmodule // src_cmd_top
`default_nettype wire

// ==== testbench/src_supply_model.sv ====
// supply-side model: live status conditions and local/remote switch
// assumes the bench requests values; they reach the block one edge later
`default_nettype none
module src_supply_model
   import src_pkg::*;
(
   input wire logic aclk,
   input wire logic [ST_W-1:0] cond_req,
   input wire logic local_req,
   output var logic [ST_W-1:0] status_live,
   output var logic local_mode
);
   timeunit 1ns;
   timeprecision 1ns;
   // conditions settle on the supply one edge after the request
   always_ff @(posedge aclk) begin
      status_live <= cond_req;
      local_mode <= local_req;
   end
endmodule // src_supply_model
`default_nettype wire

// ==== testbench/src_cmd_top_test.sv ====
// self-checking bench for the remote command subset block
// assumes short delay ticks; the watchdog bounds every bus wait
`default_nettype none
module src_cmd_top_test
   import src_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp;
   logic [ST_W-1:0] cond_req = 0, status_live;
   logic local_req = 0, local_mode;
   logic aux1_n, aux2_n, cal, fault_line, delay_running;
   logic [33:0] exp_q[$];
   int error_cnt = 0, cmp_count = 0;
   logic [7:0] r;
   always #50 aclk = ~aclk;
   src_cmd_top #(.TICK_CYC(4)) dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .status_live(status_live),
      .local_mode(local_mode), .aux_output_one_n(aux1_n), .aux_output_two_n(aux2_n),
      .calibration_mode_flag(cal), .fault_line(fault_line), .delay_running(delay_running));
   src_supply_model model (.aclk(aclk), .cond_req(cond_req), .local_req(local_req),
      .status_live(status_live), .local_mode(local_mode));
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 0;
      wvalid <= 0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk({32'h0, bresp}, {32'h0, er});
      bready <= 0;
      @(posedge aclk);
   endtask
   // read: expected word noted in the queue, compared by the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      exp_q.push_back({er, d});
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 0;
      @(posedge aclk);
   endtask
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         if (exp_q.size() == 0) chk(34'h0, 34'h1);
         else chk({rresp, rdata}, exp_q.pop_front());
      end
   end
   initial begin
      #3_000_000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      void'($urandom(21653));
      cyc(6);
      aresetn <= 1;
      @(posedge aclk);
      chk(34'({aux1_n, aux2_n, cal}), 34'h6);
      rd(REG_CTRL, 0, RESP_OKAY);
      rd(REG_DELAY, 32'(DLY_INIT_TICKS), RESP_OKAY);
      wr(REG_DELAY, 32'(DLY_MAX_TICKS), RESP_OKAY);
      rd(REG_DELAY, 32'(DLY_MAX_TICKS), RESP_OKAY);
      wr(REG_DELAY, 0, RESP_OKAY);
      // accumulated bits latch a one-cycle condition
      r = 8'($urandom()) | 8'h01;
      cond_req <= r;
      @(posedge aclk);
      cond_req <= 0;
      cyc(3);
      rd(REG_LIVE, 0, RESP_OKAY);
      rd(REG_ACCUM, 32'(r), RESP_OKAY);
      rd(REG_ACCUM, 0, RESP_OKAY);
      rd(REG_FAULT, 32'(r), RESP_OKAY);
      chk({33'h0, fault_line}, 34'h0);
      for (int i = 0; i < 4; i++) begin
         r = 8'($urandom()) & 8'h07;
         wr(REG_CTRL, 32'(r), RESP_OKAY);
         @(posedge aclk);
         chk(34'({aux1_n, aux2_n, cal}), 34'({~r[0], ~r[1], r[2]}));
         rd(REG_CTRL, 32'(r), RESP_OKAY);
      end
      // restart commands mask mode faults while the delay runs
      wr(REG_DELAY, 3, RESP_OKAY);
      for (int c = CMD_VOLTAGE_SETTING_CMD; c <= CMD_OUT_ON; c++) begin
         wr(REG_CMD, 32'h1 << c, RESP_OKAY);
         cond_req <= MODE_MASK;
         chk({33'h0, delay_running}, 34'h1);
         rd(REG_FAULT, 0, RESP_OKAY);
         cond_req <= 0;
         for (int n = 0; n < 40 && delay_running === 1'b1; n++) @(posedge aclk);
      end
      cond_req <= 8'h01;
      cyc(3);
      cond_req <= 0;
      cyc(2);
      rd(REG_FAULT, 32'h1, RESP_OKAY);
      rd(REG_ACCUM, 32'(MODE_MASK), RESP_OKAY);
      wr(REG_CTRL, 7, RESP_OKAY);
      wr(REG_CMD, 32'h41, RESP_OKAY);
      rd(REG_CTRL, 7, RESP_OKAY);
      rd(REG_ACCUM, 32'h80, RESP_OKAY);
      // clear in local mode: defaults wait for remote
      local_req <= 1;
      wr(REG_DELAY, 5, RESP_OKAY);
      wr(REG_CMD, 32'h1, RESP_OKAY);
      chk({32'h0, aux1_n, aux2_n}, 34'h0);
      chk({33'h0, fault_line}, 34'h0);
      rd(REG_FAULT, 0, RESP_OKAY);
      rd(REG_CTRL, 32'h0C, RESP_OKAY);
      rd(REG_DELAY, 32'(DLY_INIT_TICKS), RESP_OKAY);
      local_req <= 0;
      cyc(3);
      chk({32'h0, aux1_n, aux2_n}, 34'h3);
      rd(REG_CTRL, 32'h04, RESP_OKAY);
      // byte lane 0 off: write accepted but ignored
      wstrb <= 4'hE;
      wr(REG_CTRL, 32'h3, RESP_OKAY);
      rd(REG_CTRL, 32'h04, RESP_OKAY);
      wstrb <= 4'hF;
      // mid-run reset brings the lines and the flag back to idle
      aresetn <= 0;
      cyc(2);
      aresetn <= 1;
      @(posedge aclk);
      chk(34'({aux1_n, aux2_n, cal}), 34'h6);
      rd(REG_DELAY, 32'(DLY_INIT_TICKS), RESP_OKAY);
      wr(8'h20, 32'($urandom()), RESP_SLVERR);
      rd(8'h20, 0, RESP_SLVERR);
      cyc(2);
      chk(34'(exp_q.size()), 34'h0);
      end_of_test();
   end
endmodule // src_cmd_top_test
`default_nettype wire
